/* File: hdl/trap_halt_and_watchdog_unit.sv */
// Trap classification, context store, trap halt and watchdog
//
// The address map and the Wishbone slave port were left to the implementer.
module trap_halt_and_watchdog_unit (
  input wire logic clk_i, // Clock, 250 MHz
  input wire logic rst_i, // Sync reset, high
  // Wishbone slave
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  // Sequencer side
  input wire logic trap_valid_i, // Trap detected, pulse
  input wire logic [3:0] trap_cause_i, // Cause code
  input wire logic [3:0] trap_sub_i, // Failure subtype
  input wire logic [31:0] cpu_status_i, // Hardware status bits
  input wire logic [23:0] icb_addr_i, // Context block address
  input wire logic [31:0] first_word_i, // First status word
  input wire logic [31:0] second_word_i, // Second status word
  input wire logic [31:0] dev_table_i, // Device table entry
  input wire logic [31:0] dev_intr_i, // Device interrupt entry
  input wire logic blocked_i, // Interrupts blocked
  input wire logic retire_i, // Instruction retired
  input wire logic wait_i, // Wait instruction executed
  input wire logic set_processor_mode_instr_i, // Set processor mode strobe
  input wire logic set_processor_mode_instr_ten_i, // Its trap enable form
  input wire logic set_processor_mode_instr_wen_i, // Its watchdog enable form
  output logic trap_ready_o, // Can take a trap
  output logic trap_take_o, // Vector to handler, pulse
  output logic [23:0] trap_vec_o, // Handler vector
  output logic halted_o, // Processor halted
  output logic panel_active_o, // Panel interrupt-active lamp
  output logic [23:0] halt_pc_o, // PC left at halt
  // Memory write port
  output logic mem_req_o, // Write request
  output logic [23:0] mem_addr_o, // Byte address
  output logic [31:0] mem_data_o, // Write data
  input wire logic mem_ack_i // Write done
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  trap_pkg::state_type state; // Sequencer state
  logic [2:0] ctrl; // Mode, trap and watchdog enables
  logic [3:0] cause; // Captured cause
  logic [31:0] stat_word; // Captured status word
  logic [23:0] trap_context_block; // Captured block address
  logic [31:0] w_first; // Captured first word
  logic [31:0] w_second; // Captured second word
  logic [31:0] w_table; // Captured table entry
  logic [31:0] w_intr; // Captured interrupt entry
  logic [2:0] dump_idx; // Dump word index
  logic wd_trip; // Watchdog timeout pulse
  logic wd_pend; // Timeout waiting for sequencer
  logic take; // Trap accepted this cycle
  logic [3:0] take_cause; // Cause being accepted
  logic halt_now; // Accepted trap halts
  logic wb_hit; // Bus access this cycle
  logic wb_wr; // Bus write this cycle
  logic restart; // Operator leaves halt
  logic program_status_doubleword_mode; // Doubleword mode
  logic [2:0] next_idx; // Next dump index
  logic [23:0] take_vec; // Vector of the cause being accepted
  logic [23:0] cause_vec; // Vector of the captured cause
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  blocked_watchdog #(
    .LIMIT(trap_pkg::WD_LIMIT)
  ) u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .blocked_i(blocked_i),
    .retire_i(retire_i),
    .wait_i(wait_i),
    .enable_i(ctrl[trap_pkg::B_WEN]),
    .trip_o(wd_trip)
  );
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Blocking and interrupt level do not enter into acceptance
  assign program_status_doubleword_mode = ctrl[trap_pkg::B_PSD];
  assign take = (state == trap_pkg::ST_IDLE) && (trap_valid_i || wd_pend);
  assign take_cause = trap_valid_i ? trap_cause_i : trap_pkg::C_WDOG;
  // Vectors held in nets so their low bits can be sliced
  assign take_vec = trap_pkg::vector_of(take_cause);
  assign cause_vec = trap_pkg::vector_of(cause);
  // Legacy mode has no enable: arming causes always halt
  assign halt_now = trap_pkg::arms_halt(take_cause)
    && !(program_status_doubleword_mode && ctrl[trap_pkg::B_TEN]);
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
  assign restart = wb_wr && (wb_adr_i[3:2] == trap_pkg::R_CTRL)
    && wb_sel_i[1] && wb_dat_i[trap_pkg::B_RESTART];
  // Skip the second word outside doubleword mode
  assign next_idx = (dump_idx == 3'h0 && !program_status_doubleword_mode) ? 3'h2 : dump_idx + 3'h1;
  // Timeout waits here if a sequencer trap took the slot; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_pend <= 1'b0;
    end else if (wd_trip) begin
      wd_pend <= 1'b1;
    end else if (take && !trap_valid_i) begin
      wd_pend <= 1'b0;
    end
  end
  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Mode instruction overrides the enable bits of a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= trap_pkg::CTRL_RST;
    end else begin
      if (wb_wr && wb_adr_i[3:2] == trap_pkg::R_CTRL) begin
        ctrl <= wb_dat_i[2:0];
      end
      if (set_processor_mode_instr_i) begin
        ctrl[trap_pkg::B_TEN] <= set_processor_mode_instr_ten_i;
        ctrl[trap_pkg::B_WEN] <= set_processor_mode_instr_wen_i;
      end
    end
  end
  // ----------------------------------------
  // Context capture
  // ----------------------------------------
  // Sampled once so a slow memory sees a stable dump
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= 4'h0;
      stat_word <= 32'h0;
      trap_context_block <= 24'h0;
      w_first <= 32'h0;
      w_second <= 32'h0;
      w_table <= 32'h0;
      w_intr <= 32'h0;
    end else if (take) begin
      cause <= take_cause;
      // Cause and subtype name the failure
      stat_word <= trap_pkg::status_of(cpu_status_i, take_cause,
        trap_valid_i ? trap_sub_i : 4'h0);
      trap_context_block <= icb_addr_i;
      // Bit zero and the bits above the PC field pass through untouched
      w_first <= first_word_i;
      w_first[trap_pkg::PC_LSB +: trap_pkg::PC_W] <=
        take_vec[trap_pkg::PC_W-1:0];
      w_second <= second_word_i;
      w_table <= dev_table_i;
      w_intr <= dev_intr_i;
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Halting traps dump context; others store one status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= trap_pkg::ST_IDLE;
      dump_idx <= 3'h0;
    end else begin
      case (state)
        trap_pkg::ST_IDLE: begin
          if (take && halt_now) begin
            state <= trap_pkg::ST_DUMP;
            dump_idx <= 3'h0;
          end else if (take) begin
            state <= trap_pkg::ST_ICB;
          end
        end
        trap_pkg::ST_ICB: begin
          if (mem_req_o && mem_ack_i) begin
            state <= trap_pkg::ST_IDLE;
          end
        end
        trap_pkg::ST_DUMP: begin
          if (mem_req_o && mem_ack_i) begin
            if (dump_idx == trap_pkg::DUMP_LAST) begin
              state <= trap_pkg::ST_HALT;
            end else begin
              dump_idx <= next_idx;
            end
          end
        end
        trap_pkg::ST_HALT: begin
          if (restart) begin
            state <= trap_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= trap_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Memory writes
  // ----------------------------------------
  // One idle cycle between writes keeps the handshake simple
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= 24'h0;
      mem_data_o <= 32'h0;
    end else if (mem_req_o) begin
      if (mem_ack_i) begin
        mem_req_o <= 1'b0;
      end
    end else if (state == trap_pkg::ST_ICB) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= trap_context_block + trap_pkg::ICB_STAT_OFS;
      mem_data_o <= stat_word;
    end else if (state == trap_pkg::ST_DUMP) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= trap_pkg::DUMP_BASE
        + 24'(dump_idx) * trap_pkg::DUMP_STEP;
      case (dump_idx)
        3'h0: mem_data_o <= w_first;
        3'h1: mem_data_o <= w_second;
        3'h2: mem_data_o <= stat_word;
        3'h3: mem_data_o <= w_table;
        default: mem_data_o <= w_intr;
      endcase
    end
  end
  // ----------------------------------------
  // Sequencer outputs
  // ----------------------------------------
  // Ready is a cycle late, so a caller must keep watching it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_ready_o <= 1'b0;
      trap_take_o <= 1'b0;
      trap_vec_o <= 24'h0;
    end else begin
      trap_ready_o <= (state == trap_pkg::ST_IDLE) && !take;
      // Handler runs only after its status word is in memory
      trap_take_o <= (state == trap_pkg::ST_ICB) && mem_req_o && mem_ack_i;
      if (state == trap_pkg::ST_ICB) begin
        trap_vec_o <= trap_pkg::vector_of(cause);
      end
    end
  end
  // ----------------------------------------
  // Halt indication
  // ----------------------------------------
  // Reported only after the last dump write is acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      halted_o <= 1'b0;
      panel_active_o <= 1'b0;
    end else if (state == trap_pkg::ST_DUMP && mem_req_o && mem_ack_i
        && dump_idx == trap_pkg::DUMP_LAST) begin
      halted_o <= 1'b1;
      panel_active_o <= 1'b1;
    end
  end
  // PC shown at halt is the vector of the halting trap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_pc_o <= 24'h0;
    end else if (state == trap_pkg::ST_DUMP) begin
      halt_pc_o <= trap_pkg::vector_of(cause);
    end
  end
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Every access acks next cycle; the fourth slot reads the halt PC
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i[3:2])
          trap_pkg::R_CTRL: wb_dat_o <= {29'h0, ctrl};
          trap_pkg::R_STAT: wb_dat_o <= {20'h0, cause, 5'h0,
            state != trap_pkg::ST_IDLE, panel_active_o, halted_o};
          trap_pkg::R_LAST: wb_dat_o <= stat_word;
          default: wb_dat_o <= {8'h0, halt_pc_o};
        endcase
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_panel_with_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    halted_o |-> panel_active_o) else $error("halt without panel lamp");
  chk_enabled_no_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    take && program_status_doubleword_mode && ctrl[trap_pkg::B_TEN] |=> state == trap_pkg::ST_ICB)
    else $error("enabled trap halted");
  chk_unarmed_no_dump: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !trap_pkg::arms_halt(take_cause) |=> state != trap_pkg::ST_DUMP)
    else $error("unarmed cause began halt");
  chk_halt_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    take && halt_now |=> state == trap_pkg::ST_DUMP) else $error("halt not begun");
  chk_first_dump: assert property (@(posedge clk_i) disable iff (rst_i)
    state == trap_pkg::ST_DUMP && mem_req_o && dump_idx == 3'h0
    |-> mem_addr_o == trap_pkg::DUMP_BASE) else $error("first word misplaced");
  chk_second_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    state == trap_pkg::ST_DUMP && mem_req_o && !program_status_doubleword_mode
    |-> mem_addr_o != trap_pkg::DUMP_SECOND) else $error("second word in legacy mode");
  chk_halt_after_dump: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(halted_o) |-> $past(mem_ack_i) && $past(mem_addr_o) == trap_pkg::DUMP_BASE
    + 24'h000010) else $error("halt before context stored");
  chk_halt_pc: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(halted_o) |-> halt_pc_o == trap_pkg::vector_of(cause)
    && mem_data_o == w_intr) else $error("halt pc not trap vector");
  chk_icb_status: assert property (@(posedge clk_i) disable iff (rst_i)
    state == trap_pkg::ST_ICB && mem_req_o |-> mem_addr_o == trap_context_block
    + trap_pkg::ICB_STAT_OFS && mem_data_o == stat_word) else $error("bad status store");
  chk_blocked_take: assert property (@(posedge clk_i) disable iff (rst_i)
    state == trap_pkg::ST_IDLE && trap_valid_i |=> state != trap_pkg::ST_IDLE)
    else $error("trap inhibited");
  chk_take_after_icb: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_take_o |-> $past(state) == trap_pkg::ST_ICB && $past(mem_ack_i))
    else $error("vectored before status stored");
  chk_dump_pc_field: assert property (@(posedge clk_i) disable iff (rst_i)
    state == trap_pkg::ST_DUMP && mem_req_o && dump_idx == 3'h0
    |-> mem_data_o[trap_pkg::PC_LSB +: trap_pkg::PC_W] == cause_vec[trap_pkg::PC_W-1:0])
    else $error("dumped first word lacks vector");
  chk_halt_no_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    halted_o |-> !trap_take_o) else $error("halted trap vectored");
endmodule

/* File: hdl/trap_pkg.sv */
// Shared constants, types and helpers for the trap halt unit
package trap_pkg;
  // ----------------------------------------
  // Widths and limits
  // ----------------------------------------
  localparam int unsigned ADDR_W = 24; // Real address width
  localparam int unsigned WD_LIMIT = 128; // Blocked instr limit
  // ----------------------------------------
  // Trap causes
  // ----------------------------------------
  localparam logic [3:0] C_PARITY = 4'h0;
  localparam logic [3:0] C_NONPRES = 4'h1;
  localparam logic [3:0] C_UNDEF = 4'h2;
  localparam logic [3:0] C_PRIV = 4'h3;
  localparam logic [3:0] C_MCHECK = 4'h4;
  localparam logic [3:0] C_SCHECK = 4'h5;
  localparam logic [3:0] C_MAPFLT = 4'h6;
  localparam logic [3:0] C_SVC = 4'h7;
  localparam logic [3:0] C_ARITH = 4'h8;
  localparam logic [3:0] C_CALM = 4'h9;
  localparam logic [3:0] C_WDOG = 4'ha;
  // Vector table, arbitrary placement
  localparam logic [23:0] VEC_BASE = 24'h000100;
  // ----------------------------------------
  // Memory layout
  // ----------------------------------------
  localparam logic [23:0] ICB_STAT_OFS = 24'h000010; // Word 5
  localparam logic [23:0] DUMP_BASE = 24'h000530;
  localparam logic [23:0] DUMP_SECOND = 24'h000534;
  localparam logic [23:0] DUMP_STEP = 24'h000004;
  localparam logic [2:0] DUMP_LAST = 3'h4; // Five words, four in legacy mode
  localparam int unsigned PC_LSB = 1; // Program counter field
  localparam int unsigned PC_W = 18;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [1:0] R_CTRL = 2'h0; // Byte 0x00
  localparam logic [1:0] R_STAT = 2'h1; // Byte 0x04
  localparam logic [1:0] R_LAST = 2'h2; // Byte 0x08
  localparam logic [1:0] R_HPC = 2'h3; // Byte 0x0c
  localparam int unsigned B_PSD = 0; // Doubleword mode
  localparam int unsigned B_TEN = 1; // Traps enabled
  localparam int unsigned B_WEN = 2; // Watchdog enabled
  localparam int unsigned B_RESTART = 8; // Write one: leave halt
  localparam logic [2:0] CTRL_RST = 3'h0;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ICB = 4'b0010,
    ST_DUMP = 4'b0100,
    ST_HALT = 4'b1000
  } state_type;
  // Dedicated vector of a cause
  function automatic logic [23:0] vector_of(input logic [3:0] c);
    vector_of = VEC_BASE + {18'h0, c, 2'h0};
  endfunction
  // Causes that arm the halt logic
  function automatic logic arms_halt(input logic [3:0] c);
    arms_halt = (c <= C_MAPFLT) || (c == C_WDOG);
  endfunction
  // Status word: hardware bits, subtype and cause
  function automatic logic [31:0] status_of(input logic [31:0] hw,
      input logic [3:0] c, input logic [3:0] sub);
    status_of = {hw[31:8], sub, c};
  endfunction
endpackage

/* File: hdl/blocked_watchdog.sv */
// Blocked-interrupt watchdog counter
module blocked_watchdog #(
  parameter int unsigned LIMIT = trap_pkg::WD_LIMIT
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic blocked_i, // Interrupts blocked
  input wire logic retire_i, // Instruction done
  input wire logic wait_i, // Wait instruction
  input wire logic enable_i, // Count trip enabled
  output logic trip_o // Timeout pulse
);
  localparam int unsigned CW = $clog2(LIMIT + 2);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] count; // Blocked instructions so far
  logic hit; // This retire passes the limit
  assign hit = enable_i && blocked_i && retire_i && (count == LIM);
  // ----------------------------------------
  // Counter and trip
  // ----------------------------------------
  // Unblocking restarts the run of blocked instructions
  always_ff @(posedge clk_i) begin
    if (rst_i || !blocked_i || trip_o) begin
      count <= '0;
    end else if (retire_i && count != LIM) begin
      count <= count + CW'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o <= 1'b0;
    end else begin
      trip_o <= (wait_i && blocked_i) || hit;
    end
  end
  chk_wait_trip: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_i && blocked_i |=> trip_o) else $error("wait while blocked missed");
  chk_count_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(trip_o) && !$past(wait_i) |-> $past(count) == LIM && $past(enable_i))
    else $error("watchdog tripped at wrong count");
endmodule

/* File: test/mem_partner.sv */
// Memory model that takes the unit's context writes
module mem_partner (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic slow_i, // Answer late
  input wire logic req_i, // Write request
  input wire logic [23:0] addr_i, // Write address
  input wire logic [31:0] data_i, // Write data
  output logic ack_o, // Write done pulse
  output logic seen_o, // Write taken pulse
  output logic [23:0] seen_addr_o, // Address taken
  output logic [31:0] seen_data_o // Data taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt; // Cycles spent before answering
  // Answer each request once; ack never stands a second cycle
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    seen_o <= 1'b0;
    if (rst_i) begin
      wait_cnt <= 3'h0;
    end else if (req_i && !ack_o) begin
      if (!slow_i || wait_cnt == 3'h3) begin
        ack_o <= 1'b1;
        seen_o <= 1'b1;
        seen_addr_o <= addr_i;
        seen_data_o <= data_i;
        wait_cnt <= 3'h0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule

/* File: test/trap_halt_and_watchdog_unit_bench.sv */
// Self-checking bench of the trap halt and watchdog unit
module trap_halt_and_watchdog_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [23:0] a; logic [31:0] d; logic [31:0] m;} note_type;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tv = 1'b0;
  logic blk = 1'b0, ret = 1'b0, wt = 1'b0, sc = 1'b0, ten = 1'b0, wen = 1'b0, slow = 1'b0;
  logic [3:0] adr = 4'h0, cause = 4'h0, sub = 4'h0;
  logic [23:0] trap_context_block = 24'h0;
  logic [31:0] wdat = 32'h0, cpu = 32'h0, fw = 32'h0, sw = 32'h0, dt = 32'h0, di = 32'h0;
  logic [31:0] seed = 32'h2b, r;
  wire logic ack, ready, take, halted, panel, req, mack, seen;
  wire logic [23:0] vec, hpc, maddr, saddr;
  wire logic [31:0] rdat, mdata, sdata;
  int fail_count = 0, comparisons = 0;
  note_type expq[$]; // Expected memory writes, oldest first
  note_type cur;
  trap_halt_and_watchdog_unit trap_halt_and_watchdog_unit_inst (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trap_valid_i(tv),
    .trap_cause_i(cause), .trap_sub_i(sub), .cpu_status_i(cpu), .icb_addr_i(trap_context_block),
    .first_word_i(fw), .second_word_i(sw), .dev_table_i(dt), .dev_intr_i(di),
    .blocked_i(blk), .retire_i(ret), .wait_i(wt), .set_processor_mode_instr_i(sc), .set_processor_mode_instr_ten_i(ten),
    .set_processor_mode_instr_wen_i(wen), .trap_ready_o(ready), .trap_take_o(take), .trap_vec_o(vec),
    .halted_o(halted), .panel_active_o(panel), .halt_pc_o(hpc), .mem_req_o(req),
    .mem_addr_o(maddr), .mem_data_o(mdata), .mem_ack_i(mack));
  mem_partner mem_partner_inst (.clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(req),
    .addr_i(maddr), .data_i(mdata), .ack_o(mack), .seen_o(seen), .seen_addr_o(saddr),
    .seen_data_o(sdata));
  // Free-running 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Xorshift source for context values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Masked comparison of one result
  task automatic check(input logic [31:0] got, exp, msk, input string what);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Comparison of one memory write against its note
  task automatic check_mem();
    check({8'h0, saddr}, {8'h0, cur.a}, 32'hffffffff, "write address");
    check(sdata, cur.d, cur.m, "write data");
  endtask
  // Each write the memory takes is matched with the oldest note
  always @(posedge clk) begin
    if (seen === 1'b1) begin
      if (expq.size() == 0) check(32'h1, 32'h0, 32'h1, "stray write");
      else begin
        cur = expq.pop_front();
        check_mem();
      end
    end
  end
  // Classic single Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: bus never answered", $time);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Set processor mode strobe with its enable forms
  task automatic setmode(input logic t, input logic w);
    @(posedge clk);
    sc <= 1'b1;
    ten <= t;
    wen <= w;
    @(posedge clk);
    sc <= 1'b0;
  endtask
  // New random trap context, settled before use
  task automatic shuffle(input logic [3:0] c, input logic [3:0] s);
    @(posedge clk);
    cause <= c;
    sub <= s;
    cpu <= rnd();
    fw <= rnd();
    sw <= rnd();
    dt <= rnd();
    di <= rnd();
    trap_context_block <= 24'(rnd()) & 24'hfffffc;
    @(posedge clk);
  endtask
  function automatic logic [23:0] vec_exp(input logic [3:0] c);
    return trap_pkg::VEC_BASE + {18'h0, c, 2'h0};
  endfunction
  // Notes for the halt dump; doubleword mode adds the second word
  task automatic exp_halt(input logic program_status_doubleword_mode);
    push(24'h000530, {fw[31:19], 18'(vec_exp(cause)), fw[0]}, 32'hfbffffff);
    if (program_status_doubleword_mode) push(24'h000534, sw, '1);
    push(24'h000538, {cpu[31:8], sub, cause}, '1);
    push(24'h00053c, dt, '1);
    push(24'h000540, di, '1);
  endtask
  task automatic push(input logic [23:0] a, input logic [31:0] d, m);
    expq.push_back('{a, d, m});
  endtask
  // Raise a trap when the unit is idle
  task automatic fire();
    do @(posedge clk); while (ready !== 1'b1);
    tv <= 1'b1;
    @(posedge clk);
    tv <= 1'b0;
  endtask
  // Wait for vectoring or halt, then check the outcome
  task automatic finish_trap(input logic halt);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (take !== 1'b1 && halted !== 1'b1 && n < 300);
    if (take !== 1'b1 && halted !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: trap never finished", $time);
    end
    check(32'(halted), 32'(halt), 32'h1, "halted");
    check(32'(panel), 32'(halt), 32'h1, "panel");
    check(32'(expq.size()), 32'h0, '1, "writes left");
    if (halt) check({8'h0, hpc}, {8'h0, vec_exp(cause)}, '1, "halt pc");
    else check({8'h0, vec}, {8'h0, vec_exp(cause)}, '1, "vector");
  endtask
  // Status readback while halted, then restart
  task automatic halt_tail(input logic [31:0] ctrl);
    wb(1'b0, 4'h4, 32'h0);
    check(r, {20'h0, cause, 8'h03}, 32'h00000f03, "stat halted");
    wb(1'b0, 4'hc, 32'h0);
    check(r, {8'h0, vec_exp(cause)}, 32'h00ffffff, "stat pc");
    wb(1'b1, 4'h0, ctrl | 32'h100);
    wb(1'b0, 4'h4, 32'h0);
    check(r, 32'h0, 32'h3, "stat restarted");
  endtask
  task automatic print_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(r, 32'h0, 32'h107, "ctrl reset");
    wb(1'b1, 4'h0, 32'h1);
    setmode(1'b1, 1'b0);
    blk <= 1'b1;
    for (int c = 0; c < 10; c++) begin
      shuffle(4'(c), 4'(rnd()));
      push(trap_context_block + 24'h10, {cpu[31:8], sub, cause}, '1);
      fire();
      finish_trap(1'b0);
    end
    $display("test enabled traps done");
    setmode(1'b0, 1'b0);
    for (int c = 7; c < 10; c++) begin
      shuffle(4'(c), 4'(rnd()));
      push(trap_context_block + 24'h10, {cpu[31:8], sub, cause}, '1);
      fire();
      finish_trap(1'b0);
    end
    $display("test non-arming causes done");
    slow <= 1'b1;
    shuffle(trap_pkg::C_SCHECK, 4'(rnd()));
    exp_halt(1'b1);
    fire();
    finish_trap(1'b1);
    halt_tail(32'h1);
    $display("test doubleword halt done");
    wb(1'b1, 4'h0, 32'h0);
    shuffle(trap_pkg::C_PARITY, 4'(rnd()));
    exp_halt(1'b0);
    fire();
    finish_trap(1'b1);
    halt_tail(32'h0);
    slow <= 1'b0;
    $display("test legacy halt done");
    wb(1'b1, 4'h0, 32'h1);
    setmode(1'b1, 1'b1);
    shuffle(trap_pkg::C_WDOG, 4'h0);
    push(trap_context_block + 24'h10, {cpu[31:8], 8'h0a}, '1);
    ret <= 1'b1;
    repeat (128) @(posedge clk);
    ret <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(expq.size()), 32'h1, '1, "no early trip");
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    finish_trap(1'b0);
    $display("test blocked count done");
    setmode(1'b0, 1'b0);
    shuffle(trap_pkg::C_WDOG, 4'h0);
    exp_halt(1'b1);
    wt <= 1'b1;
    @(posedge clk);
    wt <= 1'b0;
    finish_trap(1'b1);
    halt_tail(32'h1);
    $display("test wait while blocked done");
    print_verdict();
  end
endmodule
